// File: src/nvc_pkg.sv
package nvc_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [3:0] NVC_OFS_CMD = 4'h0;
	localparam logic [3:0] NVC_OFS_PROT = 4'h1;
	localparam logic [3:0] NVC_OFS_STATUS = 4'h2;
	localparam logic [3:0] NVC_OFS_IRQEN = 4'h3;
	localparam logic [3:0] NVC_OFS_IRQFLAG = 4'h4;

	localparam logic [7:0] NVC_RST_CMD = 8'h00;
	localparam logic [7:0] NVC_RST_PROT = 8'h30;
	localparam logic [7:0] NVC_RST_STATUS = 8'h00;
	localparam logic [7:0] NVC_RST_IRQEN = 8'h00;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int NVC_POS_LOCK = 7;
	localparam int NVC_POS_MAP = 4;
	localparam int NVC_POS_DATAWP = 2;
	localparam int NVC_POS_BOOT_READ_GUARD = 1;
	localparam int NVC_POS_CODEWP = 0;
	localparam int NVC_POS_ERR = 4;
	localparam int NVC_POS_EEPROM_IN_PROGRESS = 1;
	localparam int NVC_POS_FLASH_IN_PROGRESS = 0;
	localparam int NVC_POS_READY = 0;

	// ----------------------------------------
	// Command codes
	// ----------------------------------------
	localparam logic [6:0] NVC_IDLE_CODE = 7'h00;
	localparam logic [6:0] NVC_NULL_OP_CODE = 7'h01;
	localparam logic [6:0] NVC_FLASH_WRITE_ARM = 7'h02;
	localparam logic [6:0] NVC_FLASH_PAGE_ERASE_ARM = 7'h08;
	localparam logic [6:0] NVC_FLASH_32_PAGE_ERASE_ARM = 7'h0d;
	localparam logic [6:0] NVC_EEPROM_WRITE_ARM = 7'h12;
	localparam logic [6:0] NVC_EEPROM_ERASE_WRITE_ARM = 7'h13;
	localparam logic [6:0] NVC_EEPROM_BYTE_ERASE_ARM = 7'h18;
	localparam logic [6:0] NVC_EEPROM_32_BYTE_ERASE_ARM = 7'h1d;
	localparam logic [6:0] NVC_FULL_ARRAY_ERASE = 7'h20;
	localparam logic [6:0] NVC_WHOLE_EEPROM_ERASE = 7'h30;

	// Error codes
	localparam logic [2:0] NVC_ERR_NONE = 3'h0;
	localparam logic [2:0] NVC_ERR_UNSUPPORTED = 3'h1;
	localparam logic [2:0] NVC_ERR_GUARDED = 3'h2;
	localparam logic [2:0] NVC_ERR_OVERLAP = 3'h3;

	// Default operation lengths in clock cycles; unlock window in executed instructions
	localparam int NVC_FLASH_OP_CYCLES = 64;
	localparam int NVC_EEPROM_OP_CYCLES = 64;
	localparam int NVC_UNLOCK_WINDOW = 4;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		NVC_TGT_NONE,
		NVC_TGT_FLASH,
		NVC_TGT_EEPROM,
		NVC_TGT_BOTH
	} nvc_target_t;

	// Decoded command
	typedef struct packed {
		logic valid;
		logic immediate;
		nvc_target_t target;
	} nvc_cmd_info_t;

	// Register port request
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} nvc_reg_req_t;

	// Store attempt from the core
	typedef struct packed {
		logic valid;
		logic to_eeprom;
		logic app_code;
		logic app_data;
	} nvc_store_t;

endpackage

// File: src/nvc_op_timer.sv
`timescale 1ns/10ps
`default_nettype none

// Busy timer standing in for the array: counts one operation to its end
module nvc_op_timer #(
	parameter int CYCLES = 64
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Control
	input wire logic start,
	// Status
	output logic busy
);
	import nvc_pkg::*;

	localparam int CW = $clog2(CYCLES + 1);
	logic [CW-1:0] count;
	logic [CW-1:0] next_count;

	// Load on start, count down to zero
	always_comb begin
		next_count = count;
		if (start) begin
			next_count = CW'(CYCLES);
		end else if (count != '0) begin
			next_count = count - 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end

	assign busy = (count != '0);

endmodule
`default_nettype wire

// File: src/nvc_unlock.sv
`timescale 1ns/10ps
`default_nettype none

// Opens a short write window after the configuration key is seen
module nvc_unlock #(
	parameter int WINDOW = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Core events
	input wire logic key_seen,
	input wire logic instr_step,
	// Window state
	output logic open
);
	import nvc_pkg::*;

	localparam int WW = $clog2(WINDOW + 1);
	logic [WW-1:0] left;
	logic [WW-1:0] next_left;

	// Key reloads; each executed instruction uses one slot
	always_comb begin
		next_left = left;
		if (key_seen) begin
			next_left = WW'(WINDOW);
		end else if (instr_step && left != '0) begin
			next_left = left - 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			left <= '0;
		end else begin
			left <= next_left;
		end
	end

	assign open = (left != '0);

endmodule
`default_nettype wire

// File: src/nvc_ctrl.sv
`timescale 1ns/10ps
`default_nettype none

module nvc_ctrl #(
	parameter int FLASH_CYCLES = nvc_pkg::NVC_FLASH_OP_CYCLES,
	parameter int EEPROM_CYCLES = nvc_pkg::NVC_EEPROM_OP_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Register port
	input wire nvc_pkg::nvc_reg_req_t req,
	output logic [7:0] rdata,
	// Core context
	input wire logic from_debug_port,
	input wire logic key_seen,
	input wire logic instr_step,
	input wire logic exec_in_boot,
	// Fuse
	input wire logic preserve_eeprom_fuse,
	// Store attempts and boot accesses
	input wire nvc_pkg::nvc_store_t store,
	input wire logic boot_read,
	input wire logic boot_fetch,
	output logic store_wait,
	output logic boot_data_zero,
	output logic boot_fetch_nop,
	// Array side
	output logic flash_start,
	output logic eeprom_start,
	output logic [1:0] flash_window_select,
	// Interrupt request
	output logic irq
);
	import nvc_pkg::*;

	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	function automatic nvc_cmd_info_t decode(input logic [6:0] c);
		nvc_cmd_info_t d;
		d = '{valid: 1'b1, immediate: 1'b0, target: NVC_TGT_NONE};
		if (c == NVC_FLASH_WRITE_ARM ||
			(c >= NVC_FLASH_PAGE_ERASE_ARM &&
			c <= NVC_FLASH_32_PAGE_ERASE_ARM)) begin
			d.target = NVC_TGT_FLASH;
		end else if (c == NVC_EEPROM_WRITE_ARM ||
			c == NVC_EEPROM_ERASE_WRITE_ARM ||
			(c >= NVC_EEPROM_BYTE_ERASE_ARM &&
			c <= NVC_EEPROM_32_BYTE_ERASE_ARM)) begin
			d.target = NVC_TGT_EEPROM;
		end else if (c == NVC_FULL_ARRAY_ERASE) begin
			d.target = NVC_TGT_BOTH;
			d.immediate = 1'b1;
		end else if (c == NVC_WHOLE_EEPROM_ERASE) begin
			d.target = NVC_TGT_EEPROM;
			d.immediate = 1'b1;
		end else if (c != NVC_IDLE_CODE && c != NVC_NULL_OP_CODE) begin
			d.valid = 1'b0;
		end
		return d;
	endfunction

	function automatic logic is_rest(input logic [6:0] c);
		return (c == NVC_IDLE_CODE || c == NVC_NULL_OP_CODE);
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [6:0] cmd;
	logic [6:0] next_cmd;
	logic lock, next_lock;
	logic [1:0] fmap, next_fmap;
	logic data_wp, next_data_wp;
	logic code_wp, next_code_wp;
	logic boot_rp, next_boot_rp;
	logic boot_rp_live, next_boot_rp_live;
	logic [2:0] err, next_err;
	logic irq_en, next_irq_en;
	logic ready_flag, next_ready_flag;
	logic flash_busy, eeprom_busy, unlocked;
	logic next_fstart, next_estart;
	logic [7:0] next_rdata;
	nvc_cmd_info_t info;
	nvc_cmd_info_t armed;
	logic wr_cmd, wr_prot, wr_stat;

	nvc_unlock #(
		.WINDOW(NVC_UNLOCK_WINDOW)
	) u_unlock (
		.clk(clk),
		.nrst(nrst),
		.key_seen(key_seen),
		.instr_step(instr_step),
		.open(unlocked)
	);

	nvc_op_timer #(
		.CYCLES(FLASH_CYCLES)
	) u_flash_timer (
		.clk(clk),
		.nrst(nrst),
		.start(flash_start),
		.busy(flash_busy)
	);

	nvc_op_timer #(
		.CYCLES(EEPROM_CYCLES)
	) u_eeprom_timer (
		.clk(clk),
		.nrst(nrst),
		.start(eeprom_start),
		.busy(eeprom_busy)
	);

	assign info = decode(req.wdata[6:0]);
	// Decoded view of the command that is armed now
	assign armed = decode(cmd);
	assign wr_cmd = req.wr && req.addr == NVC_OFS_CMD;
	assign wr_prot = req.wr && req.addr == NVC_OFS_PROT;
	assign wr_stat = req.wr && req.addr == NVC_OFS_STATUS;

	// stall stores while the EEPROM is busy
	assign store_wait = store.valid && eeprom_busy;

	// ----------------------------------------
	// Next state of registers and command engine
	// ----------------------------------------
	always_comb begin
		logic guarded;
		logic [2:0] ev_err;
		logic ev;
		guarded = 1'b0;
		ev_err = NVC_ERR_NONE;
		ev = 1'b0;
		next_cmd = cmd;
		next_lock = lock;
		next_fmap = fmap;
		next_data_wp = data_wp;
		next_code_wp = code_wp;
		next_boot_rp = boot_rp;
		next_boot_rp_live = boot_rp_live;
		next_err = err;
		next_irq_en = irq_en;
		next_ready_flag = ready_flag;
		next_fstart = 1'b0;
		next_estart = 1'b0;

		if (wr_cmd && unlocked) begin
			if (!info.valid) begin
				ev = 1'b1;
				ev_err = NVC_ERR_UNSUPPORTED;
			end else if (!is_rest(req.wdata[6:0]) &&
				((!is_rest(cmd) && req.wdata[6:0] != cmd) ||
				flash_busy || eeprom_busy)) begin
				// overlap while armed or in progress
				ev = 1'b1;
				ev_err = NVC_ERR_OVERLAP;
			end else if (info.immediate && info.target == NVC_TGT_BOTH &&
				!from_debug_port) begin
				// full erase only from the debug port
				ev = 1'b1;
				ev_err = NVC_ERR_UNSUPPORTED;
			end else begin
				next_cmd = req.wdata[6:0];
				if (info.immediate) begin
					next_fstart = (info.target == NVC_TGT_BOTH);
					next_estart = (info.target == NVC_TGT_EEPROM) ||
						!preserve_eeprom_fuse;
				end
			end
		end

		// armed operation started by a store
		if (store.valid && !store_wait) begin
			guarded = (store.app_code && code_wp) ||
				(store.app_data && data_wp);
			if (guarded && !is_rest(cmd)) begin
				ev = 1'b1;
				ev_err = NVC_ERR_GUARDED;
			end else if (armed.target == NVC_TGT_FLASH &&
				!store.to_eeprom && !flash_busy) begin
				next_fstart = 1'b1;
			end else if (armed.target == NVC_TGT_EEPROM &&
				!armed.immediate && store.to_eeprom) begin
				next_estart = 1'b1;
			end
		end

		// window select needs no unlock; lock freezes it
		if (wr_prot && !lock) begin
			next_fmap = req.wdata[NVC_POS_MAP +: 2];
		end
		// guard bits behind unlock; set-only until reset
		if (wr_prot && unlocked) begin
			next_lock = lock | req.wdata[NVC_POS_LOCK];
			next_data_wp = data_wp | req.wdata[NVC_POS_DATAWP];
			next_code_wp = code_wp | req.wdata[NVC_POS_CODEWP];
			// only boot code may set it
			if (exec_in_boot) begin
				next_boot_rp = boot_rp | req.wdata[NVC_POS_BOOT_READ_GUARD];
			end
		end
		// takes effect once execution leaves boot
		if (boot_rp && !exec_in_boot) begin
			next_boot_rp_live = 1'b1;
		end

		// clear by zero write; a new error wins
		if (wr_stat && req.wdata[NVC_POS_ERR +: 3] == 3'h0) begin
			next_err = NVC_ERR_NONE;
		end
		if (ev) begin
			next_err = ev_err;
		end

		if (req.wr && req.addr == NVC_OFS_IRQEN) begin
			next_irq_en = req.wdata[NVC_POS_READY];
		end
		// set while idle wins over the clear
		if (req.wr && req.addr == NVC_OFS_IRQFLAG &&
			req.wdata[NVC_POS_READY]) begin
			next_ready_flag = 1'b0;
		end
		if (!eeprom_busy && !eeprom_start) begin
			next_ready_flag = 1'b1;
		end
	end

	// ----------------------------------------
	// Read data, one cycle after the strobe
	// ----------------------------------------
	always_comb begin
		next_rdata = 8'h00;
		if (req.rd) begin
			case (req.addr)
				NVC_OFS_CMD: next_rdata = {1'b0, cmd};
				NVC_OFS_PROT: next_rdata = {lock, 1'b0, fmap, 1'b0,
					data_wp, boot_rp, code_wp};
				NVC_OFS_STATUS: next_rdata = {1'b0, err, 2'b00,
					eeprom_busy, flash_busy};
				NVC_OFS_IRQEN: next_rdata = {7'h00, irq_en};
				NVC_OFS_IRQFLAG: next_rdata = {7'h00, ready_flag};
				default: next_rdata = 8'h00;
			endcase
		end
	end

	// Register everything
	always_ff @(posedge clk) begin
		if (!nrst) begin
			cmd <= NVC_RST_CMD[6:0];
			lock <= NVC_RST_PROT[NVC_POS_LOCK];
			fmap <= NVC_RST_PROT[NVC_POS_MAP +: 2];
			data_wp <= NVC_RST_PROT[NVC_POS_DATAWP];
			code_wp <= NVC_RST_PROT[NVC_POS_CODEWP];
			boot_rp <= NVC_RST_PROT[NVC_POS_BOOT_READ_GUARD];
			boot_rp_live <= 1'b0;
			err <= NVC_RST_STATUS[NVC_POS_ERR +: 3];
			irq_en <= NVC_RST_IRQEN[NVC_POS_READY];
			ready_flag <= 1'b0;
			flash_start <= 1'b0;
			eeprom_start <= 1'b0;
			rdata <= 8'h00;
		end else begin
			cmd <= next_cmd;
			lock <= next_lock;
			fmap <= next_fmap;
			data_wp <= next_data_wp;
			code_wp <= next_code_wp;
			boot_rp <= next_boot_rp;
			boot_rp_live <= next_boot_rp_live;
			err <= next_err;
			irq_en <= next_irq_en;
			ready_flag <= next_ready_flag;
			flash_start <= next_fstart;
			eeprom_start <= next_estart;
			rdata <= next_rdata;
		end
	end

	assign flash_window_select = fmap;
	// boot guard on reads from elsewhere and on fetches
	assign boot_data_zero = boot_rp_live && boot_read && !exec_in_boot;
	assign boot_fetch_nop = boot_rp_live && boot_fetch;
	assign irq = irq_en && ready_flag;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_lock_set;
		lock;
	endsequence

	AST_LOCK_HOLDS: assert property (@(posedge clk) disable iff (!nrst)
		s_lock_set |=> ($stable(fmap) && lock))
		else $error("window select changed while locked");
	AST_GUARD_STICKY: assert property (@(posedge clk) disable iff (!nrst)
		data_wp |=> data_wp)
		else $error("data guard cleared without reset");
	AST_CODE_STICKY: assert property (@(posedge clk) disable iff (!nrst)
		code_wp |=> code_wp)
		else $error("code guard cleared without reset");
	AST_BAD_CODE: assert property (@(posedge clk) disable iff (!nrst)
		(wr_cmd && unlocked && !info.valid) |=> err == NVC_ERR_UNSUPPORTED)
		else $error("reserved code did not flag error");
	AST_NO_UNLOCK: assert property (@(posedge clk) disable iff (!nrst)
		(wr_cmd && !unlocked) |=> $stable(cmd))
		else $error("command changed without unlock");
	AST_EE_ERASE_NOW: assert property (@(posedge clk) disable iff (!nrst)
		(wr_cmd && unlocked && req.wdata[6:0] == NVC_WHOLE_EEPROM_ERASE
		&& is_rest(cmd) && !flash_busy && !eeprom_busy)
		|=> eeprom_start ##1 eeprom_busy)
		else $error("EEPROM erase did not start");
	AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (!nrst)
		(irq && !(req.wr && (req.addr == NVC_OFS_IRQEN ||
		req.addr == NVC_OFS_IRQFLAG))) |=> irq)
		else $error("interrupt dropped before flag clear");
	AST_READY_IDLE: assert property (@(posedge clk) disable iff (!nrst)
		(!eeprom_busy && !eeprom_start) |=> ready_flag)
		else $error("ready flag not set while idle");
	AST_STORE_WAIT: assert property (@(posedge clk) disable iff (!nrst)
		(store.valid && eeprom_busy) |-> store_wait ##1 !eeprom_start)
		else $error("store not held while EEPROM busy");

endmodule
`default_nettype wire

// File: testbench/nvc_core_model.sv
`timescale 1ns/10ps
`default_nettype none

// Core side of the block: register master, unlock key and stores
module nvc_core_model (
	// Clock
	input wire logic clk,
	// Requests to the block
	output nvc_pkg::nvc_reg_req_t req,
	output nvc_pkg::nvc_store_t store,
	output logic key_seen,
	// Wait from the block
	input wire logic store_wait
);
	import nvc_pkg::*;

	// Idle values from time zero
	initial begin
		req = '0;
		store = '0;
		key_seen = 1'b0;
	end

	// One-cycle strobe; idle lines flip so stale values never look valid
	task automatic xfer(input logic [3:0] a, input logic [7:0] d,
		input logic w);
		@(posedge clk);
		req <= {a, d, w, !w};
		@(posedge clk);
		req <= {~a, ~d, 1'b0, 1'b0};
		#1;
	endtask

	task automatic unlock();
		@(posedge clk);
		key_seen <= 1'b1;
		@(posedge clk);
		key_seen <= 1'b0;
	endtask

	task automatic put(input logic ee, input logic [1:0] sec,
		output int waits);
		@(posedge clk);
		store <= {1'b1, ee, sec};
		waits = 0;
		@(negedge clk);
		// hold the store while the block waits
		while (store_wait !== 1'b0 && waits < 100) begin
			waits++;
			@(negedge clk);
		end
		@(posedge clk);
		store <= {1'b0, !ee, ~sec};
		#1;
	endtask
endmodule

`default_nettype wire

// File: testbench/nvc_ctrl_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module nvc_ctrl_tb_top;
	import nvc_pkg::*;
	// Short operations keep the run brief
	localparam int OPC = 4;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic dbg = 1'b0;
	logic instr_step = 1'b0;
	logic in_boot = 1'b0;
	logic fuse = 1'b0;
	logic boot_read = 1'b0;
	logic boot_fetch = 1'b0;
	logic key_seen;
	nvc_reg_req_t req;
	nvc_store_t store;
	logic [7:0] rdata;
	logic store_wait, bdz, bfn, fst, est, irq;
	logic [1:0] win;
	int mismatches = 0;
	int total_checks = 0;
	int w;

	// Clock, 25 ns period
	always #12.5 clk = ~clk;

	nvc_ctrl #(.FLASH_CYCLES(OPC), .EEPROM_CYCLES(OPC)) u_nvc_ctrl (
		.clk(clk), .nrst(nrst), .req(req), .rdata(rdata),
		.from_debug_port(dbg), .key_seen(key_seen),
		.instr_step(instr_step), .exec_in_boot(in_boot),
		.preserve_eeprom_fuse(fuse), .store(store),
		.boot_read(boot_read), .boot_fetch(boot_fetch),
		.store_wait(store_wait), .boot_data_zero(bdz),
		.boot_fetch_nop(bfn), .flash_start(fst), .eeprom_start(est),
		.flash_window_select(win), .irq(irq));

	nvc_core_model u_nvc_core_model (.clk(clk), .req(req), .store(store),
		.key_seen(key_seen), .store_wait(store_wait));

	task automatic chk(input string n, input logic [7:0] s,
		input logic [7:0] e);
		total_checks++;
		if (s !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic conclude();
		if (mismatches == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		u_nvc_core_model.xfer(a, d, 1'b1);
	endtask

	task automatic rd(input string n, input logic [3:0] a,
		input logic [7:0] e);
		u_nvc_core_model.xfer(a, 8'h00, 1'b0);
		chk(n, rdata, e);
	endtask

	// Guarded write: key first, then the write at once
	task automatic pw(input logic [3:0] a, input logic [7:0] d);
		u_nvc_core_model.unlock();
		wr(a, d);
	endtask

	task automatic rst();
		@(posedge clk);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		repeat (2) @(posedge clk);
	endtask

	task automatic s_reset();
		logic [7:0] exp [6] = '{8'h00, 8'h30, 8'h00, 8'h00, 8'h01, 8'h00};
		for (int i = 0; i < 6; i++) begin
			rd("reg", 4'(i), exp[i]);
		end
		chk("win", win, 8'h03);
		wr(NVC_OFS_IRQEN, 8'hff);
		rd("ien", NVC_OFS_IRQEN, 8'h01);
		wr(NVC_OFS_IRQEN, 8'h00);
		wr(NVC_OFS_STATUS, 8'hff);
		rd("sts", NVC_OFS_STATUS, 8'h00);
	endtask

	task automatic s_arm();
		logic [7:0] codes [15] = '{8'h02, 8'h08, 8'h09, 8'h0a, 8'h0b,
			8'h0c, 8'h0d, 8'h12, 8'h13, 8'h18, 8'h19, 8'h1a, 8'h1b,
			8'h1c, 8'h1d};
		logic ee;
		for (int i = 0; i < 15; i++) begin
			ee = codes[i][4];
			pw(NVC_OFS_CMD, codes[i]);
			chk("arm", {fst, est}, 8'h00);
			u_nvc_core_model.put(ee, 2'b00, w);
			chk("fst", fst, !ee);
			chk("est", est, ee);
			rd("busy", NVC_OFS_STATUS, ee ? 8'h02 : 8'h01);
			repeat (OPC) @(posedge clk);
			rd("done", NVC_OFS_STATUS, 8'h00);
			pw(NVC_OFS_CMD, i[0] ? NVC_NULL_OP_CODE : NVC_IDLE_CODE);
		end
	endtask

	task automatic s_imm();
		wr(NVC_OFS_IRQEN, 8'h01);
		chk("irq", irq, 8'h01);
		pw(NVC_OFS_CMD, NVC_WHOLE_EEPROM_ERASE);
		chk("est", est, 8'h01);
		wr(NVC_OFS_IRQFLAG, 8'h01);
		chk("irqc", irq, 8'h00);
		repeat (OPC) @(posedge clk);
		#1;
		chk("irqs", irq, 8'h01);
		wr(NVC_OFS_IRQEN, 8'h00);
		chk("irqm", irq, 8'h00);
		pw(NVC_OFS_CMD, NVC_IDLE_CODE);
	endtask

	task automatic s_wait();
		pw(NVC_OFS_CMD, NVC_EEPROM_WRITE_ARM);
		u_nvc_core_model.put(1'b1, 2'b00, w);
		u_nvc_core_model.put(1'b1, 2'b00, w);
		chk("wait", w > 0 && w < 100, 8'h01);
		chk("est2", est, 8'h01);
		repeat (OPC) @(posedge clk);
		pw(NVC_OFS_CMD, NVC_IDLE_CODE);
	endtask

	task automatic s_err();
		pw(NVC_OFS_CMD, 8'h03);
		rd("inv", NVC_OFS_STATUS, 8'h10);
		rd("cmd", NVC_OFS_CMD, 8'h00);
		wr(NVC_OFS_STATUS, 8'h50);
		rd("keep", NVC_OFS_STATUS, 8'h10);
		wr(NVC_OFS_STATUS, 8'h00);
		rd("clr", NVC_OFS_STATUS, 8'h00);
		pw(NVC_OFS_CMD, NVC_FLASH_WRITE_ARM);
		pw(NVC_OFS_CMD, NVC_FLASH_PAGE_ERASE_ARM);
		rd("col", NVC_OFS_STATUS, 8'h30);
		rd("cmdk", NVC_OFS_CMD, 8'h02);
		pw(NVC_OFS_CMD, NVC_IDLE_CODE);
		pw(NVC_OFS_CMD, NVC_FULL_ARRAY_ERASE);
		chk("core", {fst, est}, 8'h00);
		rd("cor", NVC_OFS_STATUS, 8'h10);
		wr(NVC_OFS_STATUS, 8'h00);
	endtask

	task automatic s_full();
		@(posedge clk);
		dbg <= 1'b1;
		for (int f = 0; f < 2; f++) begin
			@(posedge clk);
			fuse <= f[0];
			pw(NVC_OFS_CMD, NVC_FULL_ARRAY_ERASE);
			chk("fer", {fst, est}, f ? 8'h02 : 8'h03);
			repeat (OPC) @(posedge clk);
			pw(NVC_OFS_CMD, NVC_IDLE_CODE);
		end
		@(posedge clk);
		dbg <= 1'b0;
	endtask

	task automatic s_prot();
		// Window stays open until instructions run; four close it, five are run
		u_nvc_core_model.unlock();
		repeat (5) begin
			@(posedge clk);
			instr_step <= 1'b1;
			@(posedge clk);
			instr_step <= 1'b0;
		end
		wr(NVC_OFS_PROT, 8'h35);
		rd("late", NVC_OFS_PROT, 8'h30);
		wr(NVC_OFS_CMD, 8'h02);
		rd("nokey", NVC_OFS_CMD, 8'h00);
		pw(NVC_OFS_PROT, 8'h7f);
		rd("wp", NVC_OFS_PROT, 8'h35);
		pw(NVC_OFS_PROT, 8'h30);
		rd("stk", NVC_OFS_PROT, 8'h35);
		for (int s = 1; s < 3; s++) begin
			pw(NVC_OFS_CMD, NVC_FLASH_WRITE_ARM);
			u_nvc_core_model.put(1'b0, 2'(s), w);
			chk("blk", fst, 8'h00);
			rd("e2", NVC_OFS_STATUS, 8'h20);
			wr(NVC_OFS_STATUS, 8'h00);
			pw(NVC_OFS_CMD, NVC_IDLE_CODE);
		end
	endtask

	task automatic s_map();
		for (int m = 0; m < 4; m++) begin
			wr(NVC_OFS_PROT, 8'(m << 4));
			chk("map", win, 8'(m));
		end
		pw(NVC_OFS_PROT, 8'hb0);
		wr(NVC_OFS_PROT, 8'h10);
		chk("lock", win, 8'h03);
		rd("lkr", NVC_OFS_PROT, 8'hb0);
	endtask

	task automatic s_boot();
		@(posedge clk);
		in_boot <= 1'b1;
		boot_read <= 1'b1;
		boot_fetch <= 1'b1;
		pw(NVC_OFS_PROT, 8'h02);
		rd("brp", NVC_OFS_PROT, 8'hb2);
		chk("inb", {bdz, bfn}, 8'h00);
		@(posedge clk);
		in_boot <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk("out", {bdz, bfn}, 8'h03);
	endtask

	// Main sequence; the second reset must clear the sticky guards
	initial begin
		rst();
		s_reset();
		s_arm();
		s_imm();
		s_wait();
		s_err();
		s_full();
		s_prot();
		rst();
		s_reset();
		s_map();
		s_boot();
		conclude();
	end

	// Cuts a hung run short
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		conclude();
	end
endmodule

`default_nettype wire
